// File: bench/backplane_interrupt_router_tb.sv
// Self-checking bench for the interrupt router
`include "bir_defs.svh"
module backplane_interrupt_router_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, ext_host; // Drives
    logic [7:0] paddr; // Address
    logic [31:0] pwdata, prdata, rq; // Data, taken read
    logic pready, pslverr, eq, iack_req, iack_done, ia_req, ia_ack; // Handshakes
    logic sigq_full, signal_dequeue, dlv_valid; // Queue, delivery
    logic [6:0] bp_irq_o, bp_irq_oe, lines; // Lines
    logic [15:0] iack_data, ia_id; // IDs
    logic [2:0] ia_level; // Far ack level
    bir_pkg::bir_iack_s iack_cmd; // Cycle request
    bir_pkg::bir_deliver_s dlv; // Delivery
    int errors = 0, n_compared = 0, n_dlv = 0; // Counters
    typedef struct packed {
        logic [7:0] wa; // Write address
        logic [31:0] wd; // Written
        logic [7:0] ra; // Read back
        logic [31:0] ex; // Expected
    } bir_row_s;
    bir_row_s rows [6] = '{
        '{`BIR_OFF_ROUTE, 32'h0000_000F, `BIR_OFF_ROUTE, 32'h0000_000F},
        '{`BIR_OFF_SIG_EN, 32'h0000_007F, `BIR_OFF_SIG_EN, 32'h0000_0070},
        '{`BIR_OFF_HDL_EN, 32'h0000_007F, `BIR_OFF_HDL_EN, 32'h0000_000F},
        '{`BIR_OFF_SIG_DIS, 32'h0000_0010, `BIR_OFF_SIG_EN, 32'h0000_0060},
        '{`BIR_OFF_HDL_DIS, 32'h0000_0001, `BIR_OFF_HDL_EN, 32'h0000_000E},
        '{`BIR_OFF_MODE, 32'h0000_0040, `BIR_OFF_MODE, 32'h0000_0040}
    };
    // Line seen by the router is far lines or our driver
    bir_router DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bp_irq_i(lines | bp_irq_oe), .bp_irq_o(bp_irq_o), .bp_irq_oe(bp_irq_oe), .ext_host(ext_host),
        .iack_req(iack_req), .iack_cmd(iack_cmd), .iack_done(iack_done), .iack_berr(1'b0),
        .iack_data(iack_data), .ia_req(ia_req), .ia_level(ia_level), .ia_ack(ia_ack), .ia_id(ia_id),
        .sigq_full(sigq_full), .signal_dequeue(signal_dequeue), .dlv_valid(dlv_valid), .dlv(dlv));
    bir_bp_model BP (.pclk(pclk), .iack_req(iack_req), .iack_cmd(iack_cmd), .iack_done(iack_done),
        .iack_data(iack_data), .lines(lines), .ia_req(ia_req), .ia_level(ia_level), .ia_ack(ia_ack),
        .ia_id(ia_id));
    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Count deliveries
    always @(posedge pclk) if (dlv_valid === 1'b1) n_dlv++;
    // Compare and report
    task chk(input logic [31:0] got, input logic [31:0] ex);
        n_compared++;
        if (got !== ex) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, ex);
        end
    endtask : chk
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        eq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Read and compare under a mask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        chk(rq & m, ex);
    endtask : rd
    // Wait for a delivery count
    task wait_dlv(input int k, input logic [19:0] ex);
        for (int i = 0; i < 300 && n_dlv < k; i++) @(posedge pclk);
        chk({12'h000, dlv}, {12'h000, ex});
    endtask : wait_dlv
    // Verdict
    task final_report();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // Watchdog
    initial begin
        #500us;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, ext_host, sigq_full, signal_dequeue} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, eq}, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            rd(rows[i].ra, 32'hFFFF_FFFF, rows[i].ex);
        end
        BP.lines[5] <= 1'b1;
        wait_dlv(1, {1'b0, 3'd6, 16'h5A06});
        BP.lines[2] <= 1'b1;
        wait_dlv(2, {1'b1, 3'd3, 16'h5A03});
        BP.release_on_register_access = 7'h40;
        BP.lines[6] <= 1'b1;
        wait_dlv(3, {1'b0, 3'd7, 16'h5A07});
        rd(`BIR_OFF_SIG_EN, 32'hFFFF_FFFF, 32'h0000_0020);
        BP.lines[0] <= 1'b1;
        repeat (30) @(posedge pclk);
        chk(n_dlv, 3);
        BP.lines[6] <= 1'b0;
        repeat (6) @(posedge pclk); // Let the released line clear the filter
        apb(1'b1, `BIR_OFF_SIG_EN, 32'h0000_0040);
        rd(`BIR_OFF_SIG_EN, 32'hFFFF_FFFF, 32'h0000_0060);
        ext_host <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_31FF);
        for (int i = 0; i < 30; i++) apb(1'b0, `BIR_OFF_STAT, 32'h0000_0000);
        rd(`BIR_OFF_ACKID, 32'hFFFF_FFFF, 32'h0000_5A01);
        chk({31'h0, BP.last_cmd.ext}, 32'h0000_0001);
        ext_host <= 1'b0;
        sigq_full <= 1'b1;
        @(posedge pclk);
        sigq_full <= 1'b0;
        rd(`BIR_OFF_SIG_EN, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(`BIR_OFF_HDL_EN, 32'hFFFF_FFFF, 32'h0000_000E);
        signal_dequeue <= 1'b1;
        @(posedge pclk);
        signal_dequeue <= 1'b0;
        rd(`BIR_OFF_SIG_EN, 32'hFFFF_FFFF, 32'h0000_0060);
        apb(1'b1, `BIR_OFF_SIG_DIS, 32'h0000_007F);
        apb(1'b1, `BIR_OFF_HDL_DIS, 32'h0000_007F);
        apb(1'b1, `BIR_OFF_ID, 32'h0000_C3A5);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_13FF);
        repeat (2) @(posedge pclk);
        chk({25'h0, bp_irq_oe}, 32'h0000_0004);
        rd(`BIR_OFF_STAT, 32'h0000_03FF, 32'h0000_0100);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_13FF);
        rd(`BIR_OFF_STAT, 32'h0000_01FF, 32'h0000_01FB);
        BP.ack_ours(3'd3);
        chk({16'h0, BP.got_id}, 32'h0000_C3A5);
        rd(`BIR_OFF_STAT, 32'h0000_0300, 32'h0000_0200);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_1200);
        repeat (2) @(posedge pclk);
        chk({25'h0, bp_irq_oe}, 32'h0000_0002);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_2200);
        repeat (2) @(posedge pclk);
        chk({25'h0, bp_irq_oe | bp_irq_o}, 32'h0000_0000);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_1212);
        rd(`BIR_OFF_STAT, 32'h0000_00FF, 32'h0000_00FE);
        apb(1'b1, `BIR_OFF_CMD, 32'h0000_10FF);
        rd(`BIR_OFF_STAT, 32'h0000_00FF, 32'h0000_00FD);
        final_report();
    end
endmodule : backplane_interrupt_router_tb

// File: bench/bir_bp_model.sv
// Far side: backplane interrupters and acknowledge logic
module bir_bp_model (
    input wire logic pclk, // Clock
    input wire logic iack_req, // Cycle request
    input wire bir_pkg::bir_iack_s iack_cmd, // Level, engine
    output logic iack_done, // Done pulse
    output logic [15:0] iack_data, // Fetched ID
    output logic [6:0] lines, // Far lines
    output logic ia_req, // Far acknowledge
    output logic [2:0] ia_level, // Its level
    input wire logic ia_ack, // Our answer
    input wire logic [15:0] ia_id // Our ID
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] release_on_register_access; // Lines kept after ack
    bir_pkg::bir_iack_s last_cmd; // Last cycle
    logic [15:0] got_id; // ID from our interrupter
    // Answer each cycle two edges later
    initial begin
        release_on_register_access = 7'h00;
        iack_done = 1'b0;
        iack_data = 16'h0000;
        lines = 7'h00;
        ia_req = 1'b0;
        ia_level = 3'h0;
        forever begin
            @(posedge pclk);
            if (iack_req === 1'b1) begin
                last_cmd = iack_cmd;
                repeat (2) @(posedge pclk);
                iack_done <= 1'b1;
                iack_data <= {8'h5A, 5'h00, iack_cmd.level};
                if (!release_on_register_access[iack_cmd.level - 3'h1]) lines[iack_cmd.level - 3'h1] <= 1'b0;
                @(posedge pclk);
                iack_done <= 1'b0;
                iack_data <= ~iack_data;
            end
        end
    end
    // Acknowledge our interrupter
    task ack_ours(input logic [2:0] lvl);
        @(posedge pclk);
        ia_req <= 1'b1;
        ia_level <= lvl;
        @(posedge pclk);
        ia_req <= 1'b0;
        ia_level <= ~lvl;
        @(posedge pclk);
        got_id = (ia_ack === 1'b1) ? ia_id : 16'h0000;
    endtask : ack_ours
endmodule : bir_bp_model

// File: core/bir_defs.svh
// Constants for the backplane interrupt router
//
// Summary of operation
// RULE_01 - Each level holds a route selection
// RULE_02 - Reset routes every level to signals
// RULE_03 - Seven levels, each with own handler
// RULE_04 - Handler gets level and raw ID
// RULE_05 - Path enables touch only their routed levels
// RULE_06 - Per-level signal path enable and disable
// RULE_07 - Per-level handler path enable and disable
// RULE_08 - Selector all-ones or local address means local
// RULE_09 - Queue full clears signal-routed enables
// RULE_10 - Dequeue restores enables cleared by full
// RULE_11 - Per-level per-controller acknowledge mode
// RULE_12 - Register-access mode clears enable on acknowledge
// RULE_13 - Software re-enables after interrupter releases
// RULE_14 - Interrupter asserts level, returns given ID
// RULE_15 - Assert completes at once, serviced flag readable
// RULE_16 - Software may withdraw unacknowledged interrupt
// RULE_17 - Enabled asserted levels are acknowledged automatically
// RULE_18 - Manual acknowledge fetches ID on request
// RULE_19 - Extended controller acknowledges through frame extender
// RULE_20 - ID low byte address, high byte reason
// RULE_21 - Acknowledge-release interrupter drops line itself
// RULE_22 - Assert while pending is refused with error
// RULE_23 - Level masks: bit n-1 is level n
`ifndef BIR_DEFS_SVH
`define BIR_DEFS_SVH
// Register byte offsets
`define BIR_OFF_ROUTE 8'h00
`define BIR_OFF_SIG_EN 8'h04
`define BIR_OFF_SIG_DIS 8'h08
`define BIR_OFF_HDL_EN 8'h0C
`define BIR_OFF_HDL_DIS 8'h10
`define BIR_OFF_MODE 8'h14
`define BIR_OFF_CMD 8'h18
`define BIR_OFF_ID 8'h1C
`define BIR_OFF_STAT 8'h20
`define BIR_OFF_ACKID 8'h24
// Command word fields
`define BIR_CMD_OP 13:12
`define BIR_CMD_LVL 10:8
`define BIR_CMD_CTL 7:0
`define BIR_OP_ASSERT 2'h1
`define BIR_OP_WITHDRAW 2'h2
`define BIR_OP_MANACK 2'h3
// Mode register halves: local then extended
`define BIR_MODE_EXT 8
// Result codes, two's complement
`define BIR_RES_OK 8'h00
`define BIR_RES_CTRL 8'hFE
`define BIR_RES_LVL 8'hFD
`define BIR_RES_BERR 8'hFC
`define BIR_RES_PEND 8'hFB
// Selector values for the local controller
`define BIR_SEL_SELF 8'hFF
`define BIR_LOCAL_LA 8'h00
// Settle time after an acknowledge
`define BIR_HOLD_CYC 3'h4
`endif

// File: core/bir_pkg.sv
// Types shared by the backplane interrupt router
package bir_pkg;
    // Acknowledge sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, // Waiting for work
        ST_IACK = 3'b010, // Acknowledge cycle running
        ST_HOLD = 3'b100  // Line settle time
    } bir_state_e;
    // One delivered status/ID
    typedef struct packed {
        logic to_handler;  // 1 handler path, 0 signal path
        logic [2:0] level; // Level 1..7
        logic [15:0] id;   // Raw status/ID
    } bir_deliver_s;
    // Acknowledge cycle request
    typedef struct packed {
        logic ext;         // Run on frame extender
        logic [2:0] level; // Level 1..7
    } bir_iack_s;
endpackage : bir_pkg

// File: core/bir_router.sv
// Backplane interrupt router with APB registers
//
// The implementer's own choices: the address map and register access over APB.
`include "bir_defs.svh"
module bir_router (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [6:0] bp_irq_i, // Backplane lines, high asserted
    output logic [6:0] bp_irq_o, // Driven level, always low
    output logic [6:0] bp_irq_oe, // Our interrupter drives line
    input wire logic ext_host, // Strap: host is external
    output logic iack_req, // Acknowledge cycle request
    output bir_pkg::bir_iack_s iack_cmd, // Level and engine
    input wire logic iack_done, // Acknowledge cycle finished
    input wire logic iack_berr, // Bus error on that cycle
    input wire logic [15:0] iack_data, // Fetched status/ID
    input wire logic ia_req, // Someone acknowledges a level
    input wire logic [2:0] ia_level, // Level being acknowledged
    output logic ia_ack, // We answer that acknowledge
    output logic [15:0] ia_id, // Our status/ID
    input wire logic sigq_full, // Signal queue became full
    input wire logic signal_dequeue, // Entry removed from queue
    output logic dlv_valid, // Delivery pulse
    output bir_pkg::bir_deliver_s dlv // Delivered level and ID
);
    // Level number to one-hot mask
    function automatic logic [6:0] lvl_mask(input logic [2:0] l);
        lvl_mask = (l == 3'h0) ? 7'h00 : 7'(7'h01 << (l - 3'h1)); // [RULE_23]
    endfunction : lvl_mask

    // Highest asserted level, zero if none
    function automatic logic [2:0] top_lvl(input logic [6:0] m);
        top_lvl = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (m[i]) begin
                top_lvl = 3'(i + 1);
            end
        end
    endfunction : top_lvl

    // Selector decode: {valid, extended}
    function automatic logic [1:0] sel_dec(input logic [7:0] s, input logic x);
        sel_dec = {(s == `BIR_SEL_SELF) || (s == `BIR_LOCAL_LA), x}; // [RULE_08]
    endfunction : sel_dec

    logic [6:0] route_r; // 1 handler path, 0 signal path
    logic [6:0] sig_en_r; // Signal path enables
    logic [6:0] hdl_en_r; // Handler path enables
    logic [6:0] auto_off_r; // Levels turned off by queue full
    logic [14:0] mode_r; // 1 register-access release
    logic [15:0] assert_id_r; // ID to present
    logic [7:0] result_r; // Last command result
    logic pending_r; // Our interrupt outstanding
    logic [2:0] pend_lvl_r; // Level we assert
    logic serviced_r; // Our interrupt was acknowledged
    logic man_req_r; // Manual acknowledge waiting
    logic man_cur_r; // Running cycle is manual
    logic [2:0] man_lvl_r; // Manual level
    logic [15:0] ack_id_r; // Last manual fetched ID
    logic [6:0] s1_r, s2_r, s3_r, irq_q_r; // Line synchroniser
    logic [2:0] x_r; // Strap synchroniser
    logic ext_q_r; // Filtered strap
    bir_pkg::bir_state_e state_r; // Sequencer state
    logic [2:0] hold_r; // Settle counter
    logic [2:0] cur_lvl_r; // Level under acknowledge
    logic cur_ext_r; // Engine of current cycle

    // Bus phases
    logic setup, wr;
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;

    // Candidates for automatic acknowledge
    logic [6:0] armed;
    logic [2:0] pick;
    assign armed = irq_q_r & ((sig_en_r & ~route_r) | (hdl_en_r & route_r)); // [RULE_05] [RULE_17]
    assign pick = top_lvl(armed);

    // Command fields
    logic [1:0] cmd_op;
    logic [2:0] cmd_lvl;
    logic [1:0] cmd_sel;
    logic cmd_go;
    assign cmd_op = pwdata[`BIR_CMD_OP];
    assign cmd_lvl = pwdata[`BIR_CMD_LVL];
    assign cmd_sel = sel_dec(pwdata[`BIR_CMD_CTL], ext_q_r);
    assign cmd_go = wr && (paddr == `BIR_OFF_CMD) && cmd_sel[1] && (cmd_lvl != 3'h0);

    // Acknowledge finishing this cycle
    logic ack_end, ack_ok, release_on_register_access;
    assign ack_end = (state_r == bir_pkg::ST_IACK) && iack_done;
    assign ack_ok = ack_end && !iack_berr;
    assign release_on_register_access = mode_r[cur_ext_r ? (`BIR_MODE_EXT + 32'(cur_lvl_r) - 1) : (32'(cur_lvl_r) - 1)];

    // Our own interrupter acknowledged
    logic own_ack;
    assign own_ack = pending_r && ia_req && (ia_level == pend_lvl_r);

    // Three-stage sync, accept when last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 7'h00;
            s2_r <= 7'h00;
            s3_r <= 7'h00;
            irq_q_r <= 7'h00;
            x_r <= 3'h0;
            ext_q_r <= 1'b0;
        end else begin
            s1_r <= bp_irq_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Hold while the last two stages disagree, follow them once they agree
            irq_q_r <= (irq_q_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
            x_r <= {x_r[1:0], ext_host};
            if (x_r[1] == x_r[2]) begin
                ext_q_r <= x_r[2];
            end
        end
    end

    // APB answer: data and ready prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (setup) begin
                unique case (paddr)
                    `BIR_OFF_ROUTE: prdata <= {25'h0, route_r};
                    `BIR_OFF_SIG_EN, `BIR_OFF_SIG_DIS: prdata <= {25'h0, sig_en_r};
                    `BIR_OFF_HDL_EN, `BIR_OFF_HDL_DIS: prdata <= {25'h0, hdl_en_r};
                    `BIR_OFF_MODE: prdata <= {17'h0, mode_r};
                    `BIR_OFF_CMD: prdata <= 32'h0000_0000;
                    `BIR_OFF_ID: prdata <= {16'h0, assert_id_r};
                    `BIR_OFF_STAT: prdata <= {13'h0, irq_q_r, ext_q_r, man_req_r || man_cur_r,
                                              serviced_r, pending_r, result_r}; // [RULE_15]
                    `BIR_OFF_ACKID: prdata <= {16'h0, ack_id_r};
                    default: pslverr <= 1'b1; // Unmapped address
                endcase
            end
        end
    end

    // Route and mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_r <= 7'h00; // [RULE_02]
            mode_r <= 15'h0000;
            assert_id_r <= 16'h0000;
        end else if (wr) begin
            if (paddr == `BIR_OFF_ROUTE) begin
                route_r <= pwdata[6:0]; // [RULE_01]
            end
            if (paddr == `BIR_OFF_MODE) begin
                mode_r <= pwdata[14:0]; // [RULE_11]
            end
            if (paddr == `BIR_OFF_ID) begin
                assert_id_r <= pwdata[15:0];
            end
        end
    end

    // Signal path enables with queue full and dequeue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_en_r <= 7'h00;
            auto_off_r <= 7'h00;
        end else begin
            logic [6:0] m;
            m = sig_en_r;
            if (wr && paddr == `BIR_OFF_SIG_EN) begin
                m = m | (pwdata[6:0] & ~route_r); // [RULE_05] [RULE_06]
            end
            if (wr && paddr == `BIR_OFF_SIG_DIS) begin
                m = m & ~(pwdata[6:0] & ~route_r); // [RULE_06]
            end
            if (signal_dequeue) begin
                m = m | (auto_off_r & ~route_r); // [RULE_10]
                auto_off_r <= 7'h00;
            end
            if (sigq_full) begin
                auto_off_r <= auto_off_r | (m & ~route_r);
                m = m & route_r; // [RULE_09]
            end
            if (ack_ok && release_on_register_access) begin
                m = m & ~lvl_mask(cur_lvl_r); // [RULE_12]
            end
            sig_en_r <= m;
        end
    end

    // Handler path enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdl_en_r <= 7'h00;
        end else begin
            logic [6:0] m;
            m = hdl_en_r;
            if (wr && paddr == `BIR_OFF_HDL_EN) begin
                m = m | (pwdata[6:0] & route_r); // [RULE_05] [RULE_07]
            end
            if (wr && paddr == `BIR_OFF_HDL_DIS) begin
                m = m & ~(pwdata[6:0] & route_r); // [RULE_07]
            end
            if (ack_ok && release_on_register_access) begin
                m = m & ~lvl_mask(cur_lvl_r); // [RULE_12] [RULE_13]
            end
            hdl_en_r <= m;
        end
    end

    // Our interrupter: assert, withdraw, answer acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
            pend_lvl_r <= 3'h0;
            serviced_r <= 1'b0;
            bp_irq_o <= 7'h00;
            bp_irq_oe <= 7'h00;
            ia_ack <= 1'b0;
            ia_id <= 16'h0000;
        end else begin
            ia_ack <= 1'b0;
            if (own_ack) begin
                pending_r <= 1'b0; // [RULE_21]
                serviced_r <= 1'b1; // [RULE_15]
                bp_irq_oe <= 7'h00;
                ia_ack <= 1'b1;
                ia_id <= assert_id_r; // [RULE_14]
            end else if (cmd_go && cmd_op == `BIR_OP_ASSERT && !pending_r) begin
                pending_r <= 1'b1; // [RULE_14] [RULE_15]
                pend_lvl_r <= cmd_lvl;
                serviced_r <= 1'b0;
                bp_irq_oe <= lvl_mask(cmd_lvl);
            end else if (cmd_go && cmd_op == `BIR_OP_WITHDRAW && pending_r && cmd_lvl == pend_lvl_r) begin
                pending_r <= 1'b0; // [RULE_16]
                bp_irq_oe <= 7'h00;
            end
        end
    end

    // Command result code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= `BIR_RES_OK;
        end else if (wr && paddr == `BIR_OFF_CMD) begin
            if (!cmd_sel[1]) begin
                result_r <= `BIR_RES_CTRL;
            end else if (cmd_lvl == 3'h0) begin
                result_r <= `BIR_RES_LVL;
            end else if (cmd_op == `BIR_OP_ASSERT && pending_r && !own_ack) begin
                result_r <= `BIR_RES_PEND; // [RULE_22]
            end else begin
                result_r <= `BIR_RES_OK;
            end
        end else if (ack_end && man_cur_r) begin
            result_r <= iack_berr ? `BIR_RES_BERR : `BIR_RES_OK;
        end
    end

    // Acknowledge sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= bir_pkg::ST_IDLE;
            hold_r <= 3'h0;
            cur_lvl_r <= 3'h0;
            cur_ext_r <= 1'b0;
            man_req_r <= 1'b0;
            man_cur_r <= 1'b0;
            man_lvl_r <= 3'h0;
            iack_req <= 1'b0;
            iack_cmd <= '0;
        end else begin
            if (cmd_go && cmd_op == `BIR_OP_MANACK && !man_req_r) begin
                man_req_r <= 1'b1; // [RULE_18]
                man_lvl_r <= cmd_lvl;
            end
            unique case (state_r)
                bir_pkg::ST_IDLE: begin
                    if (man_req_r) begin
                        man_req_r <= 1'b0;
                        man_cur_r <= 1'b1;
                        cur_lvl_r <= man_lvl_r;
                        cur_ext_r <= ext_q_r;
                        iack_req <= 1'b1;
                        iack_cmd <= '{ext: ext_q_r, level: man_lvl_r}; // [RULE_18] [RULE_19]
                        state_r <= bir_pkg::ST_IACK;
                    end else if (pick != 3'h0) begin
                        man_cur_r <= 1'b0;
                        cur_lvl_r <= pick;
                        cur_ext_r <= ext_q_r;
                        iack_req <= 1'b1;
                        iack_cmd <= '{ext: ext_q_r, level: pick}; // [RULE_17] [RULE_19]
                        state_r <= bir_pkg::ST_IACK;
                    end
                end
                bir_pkg::ST_IACK: begin
                    if (iack_done) begin
                        iack_req <= 1'b0;
                        hold_r <= `BIR_HOLD_CYC;
                        state_r <= bir_pkg::ST_HOLD;
                    end
                end
                bir_pkg::ST_HOLD: begin
                    // Let a released line clear the synchroniser
                    hold_r <= hold_r - 3'h1;
                    if (hold_r == 3'h1) begin
                        man_cur_r <= 1'b0;
                        state_r <= bir_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Delivery of fetched status/ID
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dlv_valid <= 1'b0;
            dlv <= '0;
            ack_id_r <= 16'h0000;
        end else begin
            dlv_valid <= ack_ok && !man_cur_r;
            if (ack_ok && man_cur_r) begin
                ack_id_r <= iack_data; // [RULE_18]
            end
            if (ack_ok && !man_cur_r) begin
                dlv <= '{to_handler: route_r[cur_lvl_r - 3'h1], level: cur_lvl_r,
                         id: iack_data}; // [RULE_01] [RULE_03] [RULE_04] [RULE_20]
            end
        end
    end

    // Checks
    ack_only_armed_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(iack_req) && !man_cur_r |-> armed[iack_cmd.level - 3'h1])
        else $error("auto acknowledge on unarmed level"); // [RULE_17]
    rst_route_sig_a: assert property (@(posedge pclk) $rose(presetn) |-> route_r == 7'h00)
        else $error("route not signal after reset"); // [RULE_02]
    full_clears_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        sigq_full |=> (sig_en_r & ~route_r) == 7'h00)
        else $error("queue full left signal levels enabled"); // [RULE_09]
    deq_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
        signal_dequeue && !sigq_full && !ack_end && !wr |=> (sig_en_r & (auto_off_r & ~route_r)) == 7'h00 ##0
        ($past(auto_off_r) & ~route_r & ~sig_en_r) == 7'h00)
        else $error("dequeue did not restore enables"); // [RULE_10]
    release_on_register_access_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_ok && release_on_register_access && !wr |=> ((sig_en_r | hdl_en_r) & lvl_mask(cur_lvl_r)) == 7'h00)
        else $error("register-access level still enabled"); // [RULE_12]
    pend_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == `BIR_OP_ASSERT && pending_r && !own_ack |=> result_r == `BIR_RES_PEND)
        else $error("second assert not refused"); // [RULE_22]
    assert_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == `BIR_OP_ASSERT && !pending_r && !own_ack |=> pending_r && bp_irq_oe == lvl_mask(pend_lvl_r))
        else $error("assert did not drive line"); // [RULE_14]
    withdraw_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == `BIR_OP_WITHDRAW && pending_r && cmd_lvl == pend_lvl_r && !own_ack
        |=> !pending_r && bp_irq_oe == 7'h00 && !serviced_r)
        else $error("withdraw did not release line"); // [RULE_16]
    deliver_raw_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_ok && !man_cur_r |=> dlv_valid && dlv.id == $past(iack_data) && dlv.level == $past(cur_lvl_r))
        else $error("delivery lost level or ID"); // [RULE_04]
    sel_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `BIR_OFF_CMD && pwdata[7:0] != `BIR_SEL_SELF && pwdata[7:0] != `BIR_LOCAL_LA
        |=> result_r == `BIR_RES_CTRL)
        else $error("bad selector accepted"); // [RULE_08]
endmodule : bir_router
